// file: hw/lamp_pkg.sv
// constants for the lamp pwm and bridge fault status register bank
//
// Behaviour
// - first lamp duty is (first_lamp_duty_code + 1) / 128, reset code zero.
// - second lamp duty is (second_lamp_duty_code + 1) / 128, reset code zero.
// - internal pwm drives lamp outputs only while internal_pwm_select is set.
// - first lamp pwm runs at 170 Hz with select 0, 225 Hz with 1.
// - second lamp pwm runs at 170 Hz with select 0, 225 Hz with 1.
// - overcurrent sets that switch's flag in bits 15..4 and turns it off.
// - any overcurrent flag set raises the global supply or overcurrent flag.
// - with recovery enabled, a tripped switch turns back on after the programmed delay.
// - underload flag sets when switch on and current low for the filter time.
// - any underload flag raises the global underload flag unless suppressed.
// - first bridge suppress bits withhold global underload for that bridge's switches.
// - general underload suppress withholds the global underload flag entirely.
package lamp_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] ADDR_PWM_PAIR = 5'h09;
  localparam logic [4:0] ADDR_OC_FLAGS = 5'h10;
  localparam logic [4:0] ADDR_ULD_FLAGS = 5'h11;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [15:0] PWM_PAIR_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // ==========================================================
  // field layout
  localparam int FIRST_FSEL_BIT = 15;
  localparam int FIRST_DUTY_LSB = 8;
  localparam int SECOND_FSEL_BIT = 7;
  localparam int SECOND_DUTY_LSB = 0;
  localparam int DUTY_W = 7;
  localparam int SWITCHES = 12;
  localparam int FLAG_LSB = 4;
  localparam int FIRST_HS_IDX = 11;
  localparam int FIRST_LS_IDX = 10;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_LOW_HZ = 170;
  localparam int PWM_HIGH_HZ = 225;
  localparam int PWM_STEPS = 128;
  localparam int STEP_LOW_CYCLES = CLK_HZ / (PWM_LOW_HZ * PWM_STEPS);
  localparam int STEP_HIGH_CYCLES = CLK_HZ / (PWM_HIGH_HZ * PWM_STEPS);
  localparam int ULD_FILTER_US = 10;
  localparam int ULD_FILTER_CYCLES = (ULD_FILTER_US * (CLK_HZ / 1_000_000));
  localparam int RECOVERY_UNIT_US = 100;
  localparam int RECOVERY_UNIT_CYCLES = RECOVERY_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int RECOVERY_FIELD_W = 2;
endpackage : lamp_pkg

// file: hw/pwm_chan_if.sv
// carrier between the register bank and one pwm channel
`timescale 1ns/1ps
interface pwm_chan_if;
  logic [lamp_pkg::DUTY_W-1:0] duty;
  logic fsel;
  logic enable;
  logic out;
  modport bank (output duty, output fsel, output enable, input out);
  modport chan (input duty, input fsel, input enable, output out);
endinterface : pwm_chan_if

// file: hw/lamp_pwm_gen.sv
// one internal pwm channel: 128 steps per period, two base rates
`timescale 1ns/1ps
module lamp_pwm_gen #(
  parameter int STEP_LOW = lamp_pkg::STEP_LOW_CYCLES,
  parameter int STEP_HIGH = lamp_pkg::STEP_HIGH_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  pwm_chan_if.chan ch
);
  localparam int PRE_W = $clog2(STEP_LOW + 1);

  generate
    if (STEP_LOW < 1 || STEP_HIGH < 1 || STEP_HIGH > STEP_LOW) begin : g_bad
      $error("pwm step counts out of range");
    end
  endgenerate

  logic [PRE_W-1:0] pre_q;
  logic [lamp_pkg::DUTY_W-1:0] phase_q;
  logic [PRE_W-1:0] step_last;
  logic out_q;

  // ==========================================================
  // period timing
  assign step_last = ch.fsel ? PRE_W'(STEP_HIGH - 1) : PRE_W'(STEP_LOW - 1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
      phase_q <= '0;
    end else if (ce) begin
      // >= keeps a rate change mid-step from overrunning the counter
      if (pre_q >= step_last) begin
        pre_q <= '0;
        phase_q <= phase_q + 1'b1;
      end else begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // output: high for duty+1 of 128 steps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= 1'b0;
    end else if (ce) begin
      out_q <= ch.enable && (phase_q <= ch.duty);
    end
  end

  assign ch.out = out_q;
endmodule : lamp_pwm_gen

// file: hw/lamp_pwm_and_fault_status.sv
// lamp pwm settings and sticky bridge overcurrent / underload status
`timescale 1ns/1ps
module lamp_pwm_and_fault_status #(
  parameter int STEP_LOW = lamp_pkg::STEP_LOW_CYCLES,
  parameter int STEP_HIGH = lamp_pkg::STEP_HIGH_CYCLES,
  parameter int ULD_FILTER = lamp_pkg::ULD_FILTER_CYCLES,
  parameter int RECOVERY_UNIT = lamp_pkg::RECOVERY_UNIT_CYCLES
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [lamp_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [lamp_pkg::DATA_W-1:0] REG_WDATA,
  output logic [lamp_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic INTERNAL_PWM_SELECT,
  input wire logic OC_RECOVERY_EN,
  input wire logic [lamp_pkg::RECOVERY_FIELD_W-1:0] RECOVERY_DELAY_FIELD,
  input wire logic FIRST_BRIDGE_HS_SUPPRESS,
  input wire logic FIRST_BRIDGE_LS_SUPPRESS,
  input wire logic GENERAL_UNDERLOAD_SUPPRESS,
  input wire logic [lamp_pkg::SWITCHES-1:0] SWITCH_ON_CMD,
  input wire logic [lamp_pkg::SWITCHES-1:0] OVERCURRENT_DETECT,
  input wire logic [lamp_pkg::SWITCHES-1:0] CURRENT_BELOW_THRESHOLD,
  output logic [lamp_pkg::SWITCHES-1:0] SWITCH_EN,
  output logic FIRST_LAMP_OUTPUT,
  output logic SECOND_LAMP_OUTPUT,
  output logic GLOBAL_SUPPLY_OR_OVERCURRENT_FLAG,
  output logic GLOBAL_UNDERLOAD_FLAG
);
  localparam int N = lamp_pkg::SWITCHES;
  localparam int REC_MAX = RECOVERY_UNIT * (1 << lamp_pkg::RECOVERY_FIELD_W);
  localparam int REC_W = $clog2(REC_MAX + 1);
  localparam int ULD_W = $clog2(ULD_FILTER + 1);

  generate
    if (ULD_FILTER < 1 || RECOVERY_UNIT < 1) begin : g_bad
      $error("filter and recovery counts must be at least one");
    end
  endgenerate

  // sticky flags: hardware set wins over a clearing read in the same cycle
  function automatic logic [N-1:0] sticky_next(input logic [N-1:0] cur,
                                               input logic [N-1:0] set, input logic clr);
    sticky_next = (clr ? '0 : cur) | set;
  endfunction : sticky_next

  function automatic logic [lamp_pkg::DATA_W-1:0] status_word(input logic [N-1:0] f);
    status_word = {f, lamp_pkg::FLAG_LSB'(0)};
  endfunction : status_word

  logic [lamp_pkg::DATA_W-1:0] pwm_pair_q;
  logic [N-1:0] oc_q;
  logic [N-1:0] uld_q;
  logic [N-1:0] tripped_q;
  logic [N-1:0] sw_en_q;
  logic [REC_W-1:0] rec_cnt_q [N];
  logic [ULD_W-1:0] uld_cnt_q [N];
  logic [lamp_pkg::DATA_W-1:0] rdata_q;
  logic glob_oc_q;
  logic glob_uld_q;
  logic [N-1:0] oc_set;
  logic [N-1:0] uld_set;
  logic [N-1:0] uld_visible;
  logic [REC_W-1:0] rec_target;
  logic rd_oc;
  logic rd_uld;

  // ==========================================================
  // register access
  assign rd_oc = REG_RD && (REG_ADDR == lamp_pkg::ADDR_OC_FLAGS);
  assign rd_uld = REG_RD && (REG_ADDR == lamp_pkg::ADDR_ULD_FLAGS);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pwm_pair_q <= lamp_pkg::PWM_PAIR_RESET;
    end else if (CE && REG_WR && REG_ADDR == lamp_pkg::ADDR_PWM_PAIR) begin
      pwm_pair_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= '0;
    end else if (CE && REG_RD) begin
      if (REG_ADDR == lamp_pkg::ADDR_PWM_PAIR) begin
        rdata_q <= pwm_pair_q;
      end else if (REG_ADDR == lamp_pkg::ADDR_OC_FLAGS) begin
        rdata_q <= status_word(oc_q);
      end else if (REG_ADDR == lamp_pkg::ADDR_ULD_FLAGS) begin
        rdata_q <= status_word(uld_q);
      end else begin
        rdata_q <= '0;
      end
    end
  end

  // ==========================================================
  // overcurrent: flag, shut-off and recovery
  assign oc_set = OVERCURRENT_DETECT & sw_en_q;
  assign rec_target = REC_W'(RECOVERY_UNIT * (int'(RECOVERY_DELAY_FIELD) + 1));

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      oc_q <= lamp_pkg::STATUS_RESET[lamp_pkg::DATA_W-1:lamp_pkg::FLAG_LSB];
    end else if (CE) begin
      oc_q <= sticky_next(oc_q, oc_set, rd_oc);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tripped_q <= '0;
      for (int i = 0; i < N; i++) begin
        rec_cnt_q[i] <= '0;
      end
    end else if (CE) begin
      for (int i = 0; i < N; i++) begin
        if (oc_set[i]) begin
          tripped_q[i] <= 1'b1;
          rec_cnt_q[i] <= '0;
        end else if (tripped_q[i]) begin
          if (OC_RECOVERY_EN) begin
            if (rec_cnt_q[i] >= rec_target - 1'b1) begin
              tripped_q[i] <= 1'b0;
              rec_cnt_q[i] <= '0;
            end else begin
              rec_cnt_q[i] <= rec_cnt_q[i] + 1'b1;
            end
          end else if (!oc_q[i] && !SWITCH_ON_CMD[i]) begin
            // manual restart: flag cleared and command dropped before re-arming
            tripped_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sw_en_q <= '0;
    end else if (CE) begin
      sw_en_q <= SWITCH_ON_CMD & ~tripped_q & ~oc_set;
    end
  end

  // ==========================================================
  // underload filter, only while the switch is on
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < N; i++) begin
        uld_cnt_q[i] <= '0;
      end
    end else if (CE) begin
      for (int i = 0; i < N; i++) begin
        if (!(sw_en_q[i] && CURRENT_BELOW_THRESHOLD[i])) begin
          uld_cnt_q[i] <= '0;
        end else if (uld_cnt_q[i] < ULD_W'(ULD_FILTER)) begin
          uld_cnt_q[i] <= uld_cnt_q[i] + 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      uld_set[i] = sw_en_q[i] && CURRENT_BELOW_THRESHOLD[i]
                   && (uld_cnt_q[i] >= ULD_W'(ULD_FILTER - 1));
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      uld_q <= lamp_pkg::STATUS_RESET[lamp_pkg::DATA_W-1:lamp_pkg::FLAG_LSB];
    end else if (CE) begin
      uld_q <= sticky_next(uld_q, uld_set, rd_uld);
    end
  end

  // ==========================================================
  // global indications
  always_comb begin
    uld_visible = uld_q;
    uld_visible[lamp_pkg::FIRST_HS_IDX] = uld_q[lamp_pkg::FIRST_HS_IDX]
                                          && !FIRST_BRIDGE_HS_SUPPRESS;
    uld_visible[lamp_pkg::FIRST_LS_IDX] = uld_q[lamp_pkg::FIRST_LS_IDX]
                                          && !FIRST_BRIDGE_LS_SUPPRESS;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      glob_oc_q <= 1'b0;
      glob_uld_q <= 1'b0;
    end else if (CE) begin
      glob_oc_q <= |oc_q;
      glob_uld_q <= (|uld_visible) && !GENERAL_UNDERLOAD_SUPPRESS;
    end
  end

  // ==========================================================
  // internal pwm channels
  pwm_chan_if first_ch ();
  pwm_chan_if second_ch ();

  assign first_ch.duty = pwm_pair_q[lamp_pkg::FIRST_DUTY_LSB +: lamp_pkg::DUTY_W];
  assign first_ch.fsel = pwm_pair_q[lamp_pkg::FIRST_FSEL_BIT];
  assign first_ch.enable = INTERNAL_PWM_SELECT;
  assign second_ch.duty = pwm_pair_q[lamp_pkg::SECOND_DUTY_LSB +: lamp_pkg::DUTY_W];
  assign second_ch.fsel = pwm_pair_q[lamp_pkg::SECOND_FSEL_BIT];
  assign second_ch.enable = INTERNAL_PWM_SELECT;

  lamp_pwm_gen #(.STEP_LOW(STEP_LOW), .STEP_HIGH(STEP_HIGH)) u_first (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .ch(first_ch)
  );

  lamp_pwm_gen #(.STEP_LOW(STEP_LOW), .STEP_HIGH(STEP_HIGH)) u_second (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .ch(second_ch)
  );

  assign REG_RDATA = rdata_q;
  assign SWITCH_EN = sw_en_q;
  assign FIRST_LAMP_OUTPUT = first_ch.out;
  assign SECOND_LAMP_OUTPUT = second_ch.out;
  assign GLOBAL_SUPPLY_OR_OVERCURRENT_FLAG = glob_oc_q;
  assign GLOBAL_UNDERLOAD_FLAG = glob_uld_q;
endmodule : lamp_pwm_and_fault_status

// file: verification/lamp_status_sva.sv
// port checker for the lamp pwm and fault status bank
`timescale 1ns/1ps
module lamp_status_sva #(
  parameter int ULD_FILTER = 4,
  parameter int RECOVERY_UNIT = 3
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic REG_RD,
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_RDATA,
  input wire logic INTERNAL_PWM_SELECT,
  input wire logic OC_RECOVERY_EN,
  input wire logic [1:0] RECOVERY_DELAY_FIELD,
  input wire logic GENERAL_UNDERLOAD_SUPPRESS,
  input wire logic [11:0] SWITCH_EN,
  input wire logic [11:0] OVERCURRENT_DETECT,
  input wire logic [11:0] CURRENT_BELOW_THRESHOLD,
  input wire logic FIRST_LAMP_OUTPUT,
  input wire logic SECOND_LAMP_OUTPUT,
  input wire logic GLOBAL_SUPPLY_OR_OVERCURRENT_FLAG,
  input wire logic GLOBAL_UNDERLOAD_FLAG
);
  // ==========================================================
  // properties
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  logic [11:0] trip;
  assign trip = OVERCURRENT_DETECT & SWITCH_EN;
  // off for the delay plus the enable register stage; only the short unit fits the window
  sequence s_trip_fast;
    RECOVERY_UNIT == 3 && trip[0] && OC_RECOVERY_EN && RECOVERY_DELAY_FIELD == 2'h0;
  endsequence
  // reads are excluded so a read clear cannot hide the flag
  sequence s_low_load;
    (ULD_FILTER <= 6 && SWITCH_EN[0] && CURRENT_BELOW_THRESHOLD[0]
     && !GENERAL_UNDERLOAD_SUPPRESS && !REG_RD)[*8];
  endsequence
  AST_OC_OFF: assert property (trip != 12'h000 |=> (SWITCH_EN & $past(trip)) == 12'h000)
    else $error("tripped switch still driven");
  AST_GLOBAL_OC: assert property (trip != 12'h000 |=> ##1 GLOBAL_SUPPLY_OR_OVERCURRENT_FLAG)
    else $error("global overcurrent flag missing");
  AST_RECOVER: assert property (s_trip_fast |=> (!SWITCH_EN[0])[*4] ##1 SWITCH_EN[0])
    else $error("recovery delay wrong");
  AST_ULD_SET: assert property (s_low_load |-> GLOBAL_UNDERLOAD_FLAG)
    else $error("global underload flag missing");
  AST_ULD_OFF: assert property (GENERAL_UNDERLOAD_SUPPRESS && $past(GENERAL_UNDERLOAD_SUPPRESS)
    |-> !GLOBAL_UNDERLOAD_FLAG)
    else $error("suppressed underload flag raised");
  AST_PWM_OFF: assert property (!INTERNAL_PWM_SELECT |=> !FIRST_LAMP_OUTPUT && !SECOND_LAMP_OUTPUT)
    else $error("lamp driven without internal pwm");
  AST_RD_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without read");
  AST_NIBBLE: assert property (REG_RD && REG_ADDR[4] |=> REG_RDATA[3:0] == 4'h0)
    else $error("status low bits not zero");
endmodule : lamp_status_sva
bind lamp_pwm_and_fault_status lamp_status_sva #(.ULD_FILTER(ULD_FILTER),
  .RECOVERY_UNIT(RECOVERY_UNIT)) chk (.CLK(CLK), .RESETN(RESETN), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .INTERNAL_PWM_SELECT(INTERNAL_PWM_SELECT),
  .OC_RECOVERY_EN(OC_RECOVERY_EN), .RECOVERY_DELAY_FIELD(RECOVERY_DELAY_FIELD),
  .GENERAL_UNDERLOAD_SUPPRESS(GENERAL_UNDERLOAD_SUPPRESS), .SWITCH_EN(SWITCH_EN),
  .OVERCURRENT_DETECT(OVERCURRENT_DETECT), .CURRENT_BELOW_THRESHOLD(CURRENT_BELOW_THRESHOLD),
  .FIRST_LAMP_OUTPUT(FIRST_LAMP_OUTPUT), .SECOND_LAMP_OUTPUT(SECOND_LAMP_OUTPUT),
  .GLOBAL_SUPPLY_OR_OVERCURRENT_FLAG(GLOBAL_SUPPLY_OR_OVERCURRENT_FLAG),
  .GLOBAL_UNDERLOAD_FLAG(GLOBAL_UNDERLOAD_FLAG));

// file: verification/lamp_reg_host.sv
// controller-side model issuing register strobes
`timescale 1ns/1ps
module lamp_reg_host (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [4:0] addr,
  output logic [15:0] wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
  end
  // released address and data lines show the inverse so stale values never look valid
  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : access
endmodule : lamp_reg_host

// file: verification/lamp_pwm_and_fault_status_tb.sv
// self-checking bench for the lamp pwm and fault status bank
`timescale 1ns/1ps
module lamp_pwm_and_fault_status_tb;
  logic clk, resetn, pwm_sel, rec_en, hs_sup, ls_sup, gen_sup, wr, rd, out1, out2, g_oc, g_uld;
  logic ce;
  logic [1:0] rec_field;
  logic [11:0] cmd, det, below, sw_en;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, seed, v;
  int bad_count, samples_checked, k, n;
  lamp_reg_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  lamp_pwm_and_fault_status #(.STEP_LOW(2), .STEP_HIGH(1), .ULD_FILTER(4), .RECOVERY_UNIT(3)) uut (
    .CLK(clk), .RESETN(resetn), .CE(ce), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .INTERNAL_PWM_SELECT(pwm_sel), .OC_RECOVERY_EN(rec_en),
    .RECOVERY_DELAY_FIELD(rec_field), .FIRST_BRIDGE_HS_SUPPRESS(hs_sup),
    .FIRST_BRIDGE_LS_SUPPRESS(ls_sup), .GENERAL_UNDERLOAD_SUPPRESS(gen_sup), .SWITCH_ON_CMD(cmd),
    .OVERCURRENT_DETECT(det), .CURRENT_BELOW_THRESHOLD(below), .SWITCH_EN(sw_en),
    .FIRST_LAMP_OUTPUT(out1), .SECOND_LAMP_OUTPUT(out2),
    .GLOBAL_SUPPLY_OR_OVERCURRENT_FLAG(g_oc), .GLOBAL_UNDERLOAD_FLAG(g_uld));
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // high cycles in a 512-cycle window: four periods at fast rate, two at slow
  function automatic logic [15:0] exp_hi(input logic [6:0] c, input logic sel);
    return sel ? (16'(c) + 16'h1) * 16'h4 : 16'h0;
  endfunction : exp_hi
  function automatic logic [15:0] exp_up(input logic [7:0] f, input logic sel);
    return (!sel || f[6:0] == 7'h7f) ? 16'h0 : (f[7] ? 16'h4 : 16'h2);
  endfunction : exp_up
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] want);
    host.access(1'b0, a, 16'h0000);
    #1;
    check(rdata, want);
  endtask : rd_chk
  task automatic pwm_chk(input logic [15:0] x, input logic sel);
    logic [15:0] hi1, hi2, up1, up2;
    logic p1, p2;
    host.access(1'b1, 5'h09, x);
    pwm_sel <= sel;
    repeat (600) @(posedge clk);
    #1;
    {hi1, hi2, up1, up2} = '0;
    p1 = out1;
    p2 = out2;
    repeat (512) begin
      @(posedge clk);
      #1;
      hi1 = hi1 + 16'(out1);
      hi2 = hi2 + 16'(out2);
      up1 = up1 + 16'(out1 && !p1);
      up2 = up2 + 16'(out2 && !p2);
      p1 = out1;
      p2 = out2;
    end
    check(hi1, exp_hi(x[14:8], sel));
    check(hi2, exp_hi(x[6:0], sel));
    check(up1, exp_up(x[15:8], sel));
    check(up2, exp_up(x[7:0], sel));
    rd_chk(5'h09, x);
  endtask : pwm_chk
  task automatic trip(input int i);
    @(posedge clk);
    det[i] <= 1'b1;
    @(posedge clk);
    det[i] <= 1'b0;
    #1;
    check(16'(sw_en[i]), 16'h0);
  endtask : trip
  // s holds high-side, low-side and general suppress, then the expected global flag
  task automatic uld_case(input int i, input logic on, input logic [3:0] s);
    @(posedge clk);
    {hs_sup, ls_sup, gen_sup} <= s[3:1];
    cmd[i] <= on;
    below[i] <= 1'b1;
    repeat (8) @(posedge clk);
    below[i] <= 1'b0;
    #1;
    check(16'(g_uld), 16'(s[0]));
    rd_chk(5'h11, on ? 16'h1 << (i + 4) : 16'h0);
    @(posedge clk);
    cmd[i] <= 1'b1;
  endtask : uld_case
  // ==========================================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial begin
    {resetn, pwm_sel, rec_en, hs_sup, ls_sup, gen_sup, rec_field} = '0;
    {cmd, det, below} = '0;
    ce = 1'b1;
    seed = 16'hd2bb;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(5'h09, 16'h0000);
    rd_chk(5'h10, 16'h0000);
    rd_chk(5'h11, 16'h0000);
    host.access(1'b1, 5'h10, 16'hffff);
    rd_chk(5'h10, 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    // a write while the enable is low must leave the register untouched
    @(posedge clk);
    ce <= 1'b0;
    host.access(1'b1, 5'h09, 16'h1234);
    ce <= 1'b1;
    rd_chk(5'h09, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hff80 : (i == 2) ? 16'h7f7f : seed;
      seed = lfsr(seed);
      pwm_chk(v, i != 5);
    end
    @(posedge clk);
    cmd <= 12'hfff;
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 11 : (i == 1) ? 0 : int'(seed % 16'd12);
      seed = lfsr(seed);
      repeat (4) @(posedge clk);
      trip(k);
      @(posedge clk);
      #1;
      check(16'(g_oc), 16'h1);
      rd_chk(5'h10, 16'h1 << (k + 4));
      rd_chk(5'h10, 16'h0000);
      check(16'(g_oc), 16'h0);
      check(16'(sw_en[k]), 16'h0);
      @(posedge clk);
      cmd[k] <= 1'b0;
      @(posedge clk);
      cmd[k] <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(16'(sw_en), 16'h0fff);
    end
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      rec_en <= 1'b1;
      rec_field <= 2'(f);
      repeat (2) @(posedge clk);
      trip(0);
      n = 0;
      while (!sw_en[0] && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 100) begin
        bad_count++;
        final_report();
      end
      // delay plus one: the switch enable is registered after the trip clears
      check(16'(n), 16'((f + 1) * 3 + 1));
      rd_chk(5'h10, 16'h0010);
    end
    uld_case(11, 1'b1, 4'b1000);
    uld_case(10, 1'b1, 4'b0100);
    uld_case(11, 1'b1, 4'b0101);
    uld_case(0, 1'b1, 4'b1101);
    uld_case(3, 1'b1, 4'b0010);
    uld_case(5, 1'b0, 4'b0000);
    final_report();
  end
endmodule : lamp_pwm_and_fault_status_tb
